/* File: rtl/wb_pipe_handoff.sv */
// writeback pipe handoff: axi4-lite registers, mem-to-mem job, panel handoff
// assumes one clock; pixel side is modelled by flag outputs per frame
// Summary of operation
// (R1) setting the mem-to-mem select bit of the writeback attribute register puts writeback in mem-to-mem mode.
// (R2) at the end of a mem-to-mem job the hardware clears the writeback enable bit by itself.
// (R3) the enable bit of the feeding pipe stays set after a mem-to-mem job; hardware never clears it.
// (R4) a pipe still enabled from mem-to-mem use and turned to the panel is not aligned to a frame start.
// (R5) such an unaligned reconnection raises sync-lost and gives exactly one corrupted frame.
// (R6) software first clears the pipe enable after hardware has cleared the writeback enable.
// (R7) software then sets the writeback enable and clears it again.
// (R8) software turns the pipe to the panel and reprograms it while the pipe is disabled.
// (R9) software finally sets the pipe enable again.
// (R10) a pipe enabled toward the panel from disabled starts at the next frame start, without sync-lost.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module wb_pipe_handoff #(
    parameter logic [15:0] m2m_cycles   = wb_handoff_pkg::m2m_frame_cycles,
    parameter logic [15:0] frame_cycles = wb_handoff_pkg::panel_frame_cycles
) (
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    output wb_handoff_pkg::pixel_flags_t panel_flags_out,
    output logic             m2m_busy_out,
    output logic             irq_out
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic                        wb_enable;
    logic                        m2m_select;
    logic                        pipe_enable;
    logic                        pipe_to_panel;
    logic [2:0]                  irq_status;
    logic [2:0]                  irq_mask;
    logic [15:0]                 m2m_count;
    logic                        corrupt_pending;
    wb_handoff_pkg::pipe_state_t state;
    wb_handoff_pkg::pipe_state_t next_state;

    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        aw_held;
    logic        w_held;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire        aw_take  = s_axi_awvalid_in & s_axi_awready_out;
    wire        w_take   = s_axi_wvalid_in & s_axi_wready_out;
    wire        do_write = aw_held & w_held & ~s_axi_bvalid_out;
    wire        ar_take  = s_axi_arvalid_in & s_axi_arready_out;
    wire        wr_wb    = do_write & (aw_addr == wb_handoff_pkg::writeback_attr_reg_off);
    wire        wr_pipe  = do_write & (aw_addr == wb_handoff_pkg::video_pipe_attr_reg_off);
    wire        wr_mask  = do_write & (aw_addr == wb_handoff_pkg::irq_mask_off);
    wire        wr_hit   = wr_wb | wr_pipe | wr_mask;
    wire        rd_stat  = ar_take & (s_axi_araddr_in == wb_handoff_pkg::irq_status_off);
    wire        wb_wr_b0 = wr_wb & w_strb[0];
    wire        wb_wr_b2 = wr_wb & w_strb[2];
    wire        pipe_wr  = wr_pipe & w_strb[0];
    wire        next_wb_en   = wb_wr_b0 ? w_data[wb_handoff_pkg::wb_enable_bit] : wb_enable;
    wire        next_m2m_sel = wb_wr_b2 ? w_data[wb_handoff_pkg::wb_mem_to_mem_select] : m2m_select;

    logic [31:0] rd_data;
    logic        rd_hit;
    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 32'h0000_0000;
        case (s_axi_araddr_in)
            wb_handoff_pkg::writeback_attr_reg_off: begin
                rd_data[wb_handoff_pkg::wb_enable_bit]        = wb_enable;
                rd_data[wb_handoff_pkg::wb_mem_to_mem_select] = m2m_select;
            end
            wb_handoff_pkg::video_pipe_attr_reg_off: begin
                rd_data[wb_handoff_pkg::pipe_enable_bit]   = pipe_enable;
                rd_data[wb_handoff_pkg::pipe_to_panel_bit] = pipe_to_panel;
            end
            wb_handoff_pkg::irq_status_off: rd_data[2:0] = irq_status;
            wb_handoff_pkg::irq_mask_off:   rd_data[2:0] = irq_mask;
            wb_handoff_pkg::frame_status_off: rd_data[1:0] = state;
            default: rd_hit = 1'b0;
        endcase
    end

    // ----------------------------------------
    // frame timing and events
    // ----------------------------------------
    logic frame_tick;
    frame_timer #(
        .period (frame_cycles)
    ) u_frame_timer (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .run_in   (1'b1),
        .tick_out (frame_tick)
    );

    wire m2m_active = wb_enable & m2m_select & pipe_enable & ~pipe_to_panel; // R1
    wire m2m_done   = m2m_active & (m2m_count == m2m_cycles - 16'h0001);
    // pipe still enabled and redirected on the fly, no frame alignment
    wire hot_switch = pipe_wr & pipe_enable & ~pipe_to_panel
                      & w_data[wb_handoff_pkg::pipe_enable_bit]
                      & w_data[wb_handoff_pkg::pipe_to_panel_bit]; // R4
    // pipe enabled toward the panel from disabled
    wire cold_start = pipe_wr & ~pipe_enable
                      & w_data[wb_handoff_pkg::pipe_enable_bit]
                      & w_data[wb_handoff_pkg::pipe_to_panel_bit]; // R10
    wire [2:0] irq_events = {frame_tick & (state == wb_handoff_pkg::pipe_panel), m2m_done, hot_switch};

    always_comb begin
        next_state = state;
        case (state)
            wb_handoff_pkg::pipe_idle:    next_state = cold_start ? wb_handoff_pkg::pipe_wait_fs : state;
            wb_handoff_pkg::pipe_m2m:     next_state = hot_switch ? wb_handoff_pkg::pipe_panel : state;
            wb_handoff_pkg::pipe_wait_fs: next_state = frame_tick ? wb_handoff_pkg::pipe_panel : state; // R10
            wb_handoff_pkg::pipe_panel:   next_state = state;
            default:                      next_state = wb_handoff_pkg::pipe_idle;
        endcase
        if (pipe_wr && !w_data[wb_handoff_pkg::pipe_enable_bit])
            next_state = wb_handoff_pkg::pipe_idle;
        else if (state == wb_handoff_pkg::pipe_idle && pipe_wr && w_data[wb_handoff_pkg::pipe_enable_bit]
                 && !w_data[wb_handoff_pkg::pipe_to_panel_bit])
            next_state = wb_handoff_pkg::pipe_m2m;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            wb_enable       <= 1'b0;
            m2m_select      <= 1'b0;
            pipe_enable     <= 1'b0;
            pipe_to_panel   <= 1'b0;
            irq_mask        <= wb_handoff_pkg::mask_reset;
            irq_status      <= 3'h0;
            m2m_count       <= 16'h0000;
            corrupt_pending <= 1'b0;
            state           <= wb_handoff_pkg::pipe_idle;
        end else begin
            wb_enable  <= m2m_done ? 1'b0 : next_wb_en; // R2 R7
            m2m_select <= next_m2m_sel;
            if (pipe_wr) begin
                pipe_enable   <= w_data[wb_handoff_pkg::pipe_enable_bit]; // R3 R6 R9
                pipe_to_panel <= w_data[wb_handoff_pkg::pipe_to_panel_bit]; // R8
            end
            if (wr_mask && w_strb[0])
                irq_mask <= w_data[2:0];
            irq_status <= (rd_stat ? 3'h0 : irq_status) | irq_events; // R5
            m2m_count  <= (m2m_active && !m2m_done) ? m2m_count + 16'h0001 : 16'h0000;
            if (hot_switch)
                corrupt_pending <= 1'b1; // R5
            else if (frame_tick)
                corrupt_pending <= 1'b0;
            state <= next_state;
        end
    end

    // ----------------------------------------
    // bus handshakes and outputs
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            aw_held           <= 1'b0;
            w_held            <= 1'b0;
            aw_addr           <= 8'h00;
            w_data            <= 32'h0000_0000;
            w_strb            <= 4'h0;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out  <= 1'b0;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= 2'h0;
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= 2'h0;
            panel_flags_out   <= '0;
            m2m_busy_out      <= 1'b0;
            irq_out           <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_in;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
            s_axi_awready_out <= ~aw_held & ~aw_take & ~s_axi_bvalid_out;
            s_axi_wready_out  <= ~w_held & ~w_take & ~s_axi_bvalid_out;
            if (do_write) begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= wr_hit ? 2'h0 : 2'h2;
            end else if (s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
            s_axi_arready_out <= ~s_axi_rvalid_out & ~ar_take;
            if (ar_take) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out  <= rd_data;
                s_axi_rresp_out  <= rd_hit ? 2'h0 : 2'h2;
            end else if (s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
            panel_flags_out.valid       <= (state == wb_handoff_pkg::pipe_panel);
            panel_flags_out.corrupt     <= corrupt_pending | hot_switch; // R5
            panel_flags_out.frame_start <= frame_tick;
            m2m_busy_out                <= m2m_active;
            irq_out                     <= |(irq_status & irq_mask);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_m2m_autoclear;
        @(posedge clk_in) disable iff (reset_in) m2m_done |=> !wb_enable;
    endproperty
    a_m2m_autoclear: assert property (p_m2m_autoclear) else $error("writeback enable not cleared"); // R2

    property p_pipe_kept;
        @(posedge clk_in) disable iff (reset_in) (m2m_done && !pipe_wr) |=> pipe_enable;
    endproperty
    a_pipe_kept: assert property (p_pipe_kept) else $error("pipe enable dropped by hardware"); // R3

    sequence s_hot_aftermath;
        (irq_status[wb_handoff_pkg::irq_sync_lost_bit] && panel_flags_out.corrupt) ##1 panel_flags_out.corrupt;
    endsequence

    property p_hot_synclost;
        @(posedge clk_in) disable iff (reset_in) hot_switch |=> s_hot_aftermath;
    endproperty
    a_hot_synclost: assert property (p_hot_synclost) else $error("no sync-lost on hot switch"); // R5

    property p_hot_unaligned;
        @(posedge clk_in) disable iff (reset_in) hot_switch |=> state == wb_handoff_pkg::pipe_panel;
    endproperty
    a_hot_unaligned: assert property (p_hot_unaligned) else $error("hot switch was aligned"); // R4

    property p_cold_aligned;
        @(posedge clk_in) disable iff (reset_in) cold_start |=> !irq_status[0] || $past(irq_status[0]);
    endproperty
    a_cold_aligned: assert property (p_cold_aligned) else $error("sync-lost on clean start"); // R10

    property p_cold_waits;
        @(posedge clk_in) disable iff (reset_in)
            (state == wb_handoff_pkg::pipe_wait_fs && !frame_tick && !pipe_wr) |=> state != wb_handoff_pkg::pipe_panel;
    endproperty
    a_cold_waits: assert property (p_cold_waits) else $error("panel started before frame start"); // R10

    property p_mode_select;
        @(posedge clk_in) disable iff (reset_in) (!m2m_select || !wb_enable) |=> !m2m_busy_out;
    endproperty
    a_mode_select: assert property (p_mode_select) else $error("m2m active without mode bit"); // R1

    property p_irq_level;
        @(posedge clk_in) disable iff (reset_in) (|(irq_status & irq_mask)) |=> irq_out;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");
endmodule
`default_nettype wire

/* File: rtl/wb_handoff_pkg.sv */
// package for the writeback pipe handoff block: register map, fields, types
// assumes a 32-bit axi4-lite register bus on a single clock
package wb_handoff_pkg;
    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] writeback_attr_reg_off  = 8'h00;
    localparam logic [7:0] video_pipe_attr_reg_off = 8'h04;
    localparam logic [7:0] irq_status_off          = 8'h08;
    localparam logic [7:0] irq_mask_off            = 8'h0c;
    localparam logic [7:0] frame_status_off        = 8'h10;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int wb_enable_bit          = 0;
    localparam int wb_mem_to_mem_select   = 19;
    localparam int pipe_enable_bit        = 0;
    localparam int pipe_to_panel_bit      = 1;
    localparam int irq_sync_lost_bit      = 0;
    localparam int irq_m2m_done_bit       = 1;
    localparam int irq_frame_start_bit    = 2;
    // ----------------------------------------
    // reset values and counts
    // ----------------------------------------
    localparam logic [31:0] attr_reset   = 32'h0000_0000;
    localparam logic [2:0]  mask_reset   = 3'h0;
    localparam int          irq_width    = 3;
    localparam logic [15:0] m2m_frame_cycles = 16'h0040;
    localparam logic [15:0] panel_frame_cycles = 16'h0100;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        pipe_idle    = 2'b00,
        pipe_m2m     = 2'b01,
        pipe_wait_fs = 2'b10,
        pipe_panel   = 2'b11
    } pipe_state_t;

    typedef struct packed {
        logic valid;
        logic corrupt;
        logic frame_start;
    } pixel_flags_t;
endpackage

/* File: rtl/frame_timer.sv */
// free-running frame timer giving a one-cycle frame start pulse
// assumes the period is a count of clk_in cycles
`timescale 1ns/100ps
`default_nettype none
module frame_timer #(
    parameter logic [15:0] period = 16'h0100
) (
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic run_in,
    output logic      tick_out
);
    logic [15:0] count;
    wire         wrap = (count == period - 16'h0001);

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            count    <= 16'h0000;
            tick_out <= 1'b0;
        end else begin
            tick_out <= run_in & wrap;
            count    <= (!run_in || wrap) ? 16'h0000 : count + 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* File: tb/panel_sink.sv */
// panel sink model: counts frame starts, frames shown and frames seen corrupted
// assumes the flag outputs are registered on clk_in
`timescale 1ns/100ps
`default_nettype none
module panel_sink (
    input  wire logic                         clk_in,
    input  wire logic                         reset_in,
    input  wire wb_handoff_pkg::pixel_flags_t flags_in,
    output logic [15:0]                       frame_count_out,
    output logic [15:0]                       corrupt_count_out,
    output logic [15:0]                       shown_count_out
);
    logic corrupt_seen;
    // a frame counts as corrupted if corrupt was high in any cycle after its start
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            frame_count_out   <= 16'h0;
            corrupt_count_out <= 16'h0;
            shown_count_out   <= 16'h0;
            corrupt_seen      <= 1'b0;
        end else if (flags_in.frame_start) begin
            frame_count_out   <= frame_count_out + 16'h1;
            corrupt_count_out <= corrupt_count_out + {15'h0, corrupt_seen};
            shown_count_out   <= shown_count_out + {15'h0, flags_in.valid};
            corrupt_seen      <= 1'b0;
        end else begin
            corrupt_seen      <= corrupt_seen | flags_in.corrupt;
        end
    end
endmodule
`default_nettype wire

/* File: tb/wb_pipe_handoff_tb.sv */
// testbench for the writeback pipe handoff block
// assumes axi4-lite register access and shortened job and frame lengths
`timescale 1ns/100ps
`default_nettype none
module wb_pipe_handoff_tb;
    localparam logic [7:0] wb_off = wb_handoff_pkg::writeback_attr_reg_off;
    localparam logic [7:0] pipe_off = wb_handoff_pkg::video_pipe_attr_reg_off;
    localparam logic [7:0] stat_off = wb_handoff_pkg::irq_status_off;
    localparam logic [7:0] mask_off = wb_handoff_pkg::irq_mask_off;
    localparam logic [7:0] state_off = wb_handoff_pkg::frame_status_off;
    logic clk_in, reset_in, aw_valid, w_valid, b_ready, ar_valid, r_ready;
    logic awready, wready, bvalid, arready, rvalid, busy, irq, irq_a;
    logic [7:0] aw_addr, ar_addr;
    logic [31:0] w_data, rdata, d;
    logic [3:0] w_strb;
    logic [1:0] bresp, rresp, r;
    logic [15:0] frames, corrupts, shown;
    wb_handoff_pkg::pixel_flags_t flags;
    int errors, check_count;
    wb_pipe_handoff #(.m2m_cycles(16'h0010), .frame_cycles(16'h0010)) wb_pipe_handoff_i (
        .clk_in(clk_in), .reset_in(reset_in),
        .s_axi_awaddr_in(aw_addr), .s_axi_awvalid_in(aw_valid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(w_data), .s_axi_wstrb_in(w_strb), .s_axi_wvalid_in(w_valid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(b_ready), .s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_valid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(r_ready), .panel_flags_out(flags),
        .m2m_busy_out(busy), .irq_out(irq));
    panel_sink panel_sink_i (.clk_in(clk_in), .reset_in(reset_in), .flags_in(flags),
        .frame_count_out(frames), .corrupt_count_out(corrupts), .shown_count_out(shown));
    always #50 clk_in = ~clk_in;
    // ----------------------------------------
    // bus tasks and checks
    // ----------------------------------------
    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] seen);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic aw_done, w_done, ta, tw;
        aw_done = 0;
        w_done = 0;
        @(posedge clk_in);
        aw_addr  <= a;
        aw_valid <= 1'b1;
        w_data   <= v;
        w_strb   <= 4'hf;
        w_valid  <= 1'b1;
        b_ready  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(negedge clk_in);
            ta = !aw_done && (awready === 1'b1);
            tw = !w_done && (wready === 1'b1);
            @(posedge clk_in);
            if (ta) begin
                aw_valid <= 1'b0;
                aw_done = 1;
            end
            if (tw) begin
                w_valid <= 1'b0;
                w_done = 1;
            end
        end
        do @(negedge clk_in); while (bvalid !== 1'b1);
        resp = bresp;
        @(posedge clk_in);
        b_ready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge clk_in);
        ar_addr  <= a;
        ar_valid <= 1'b1;
        r_ready  <= 1'b1;
        do @(negedge clk_in); while (arready !== 1'b1);
        @(posedge clk_in);
        ar_valid <= 1'b0;
        do @(negedge clk_in); while (rvalid !== 1'b1);
        v = rdata;
        resp = rresp;
        @(posedge clk_in);
        r_ready <= 1'b0;
    endtask
    task automatic do_reset();
        @(posedge clk_in);
        reset_in <= 1'b1;
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask
    task automatic wait_frames(input logic [15:0] n);
        logic [15:0] start;
        start = frames;
        while (frames < start + n) @(negedge clk_in);
    endtask
    task automatic run_job();
        axi_write(pipe_off, 32'h1, r);
        axi_write(wb_off, 32'h1, r);
        repeat (4) @(negedge clk_in);
        check_val("busy without select", 32'h0, {31'h0, busy});
        axi_write(wb_off, 32'h0008_0001, r);
        axi_read(state_off, d, r);
        check_val("state in job", 32'h1, d);
        while (busy !== 1'b0) @(negedge clk_in);
        axi_read(wb_off, d, r);
        check_val("wb attr after job", 32'h0008_0000, d);
        axi_read(pipe_off, d, r);
        check_val("pipe attr after job", 32'h1, d);
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #(100 * 50000);
        errors++;
        report_and_stop();
    end
    initial begin
        clk_in = 0; reset_in = 1; aw_addr = 0; aw_valid = 0; w_data = 0; w_strb = 0; w_valid = 0;
        b_ready = 0; ar_addr = 0; ar_valid = 0; r_ready = 0; errors = 0; check_count = 0;
        do_reset();
        for (int i = 0; i < 6; i++) begin
            axi_read(8'(i * 4), d, r);
            check_val("reset value", 32'h0, d);
            check_val("read resp", (i == 5) ? 32'h2 : 32'h0, {30'h0, r});
        end
        axi_write(8'h14, 32'hffff_ffff, r);
        check_val("unmapped write resp", 32'h2, {30'h0, r});
        run_job();
        axi_write(mask_off, 32'h0, r);
        @(negedge clk_in) irq_a = irq;
        axi_write(mask_off, 32'h7, r);
        @(negedge clk_in) check_val("mask changes irq", 32'h1, {31'h0, irq_a ^ irq});
        axi_read(stat_off, d, r);
        check_val("done status", 32'h2, d);
        axi_read(stat_off, d, r);
        check_val("status cleared", 32'h0, d);
        @(negedge clk_in) check_val("irq cleared", 32'h0, {31'h0, irq});
        // clean exit sequence, then a frame-aligned start on the panel
        axi_write(pipe_off, 32'h0, r);
        axi_write(wb_off, 32'h1, r);
        axi_write(wb_off, 32'h0, r);
        axi_write(pipe_off, 32'h2, r);
        axi_write(pipe_off, 32'h3, r);
        wait_frames(16'h2);
        check_val("clean corrupt frames", 32'h0, {16'h0, corrupts});
        check_val("clean shown nonzero", 32'h1, {31'h0, shown != 16'h0});
        axi_read(stat_off, d, r);
        check_val("clean sync lost", 32'h0, d & 32'h1);
        check_val("panel frame irq", 32'h4, d & 32'h4);
        axi_read(state_off, d, r);
        check_val("clean state", 32'h3, d);
        // hot switch of a pipe still enabled from the job
        do_reset();
        run_job();
        axi_write(pipe_off, 32'h3, r);
        @(negedge clk_in) check_val("corrupt on hot switch", 32'h1, {31'h0, flags.corrupt});
        axi_read(state_off, d, r);
        check_val("hot state", 32'h3, d);
        axi_read(stat_off, d, r);
        check_val("hot sync lost", 32'h1, d & 32'h1);
        wait_frames(16'h3);
        check_val("hot corrupt frames", 32'h1, {16'h0, corrupts});
        check_val("corrupt ends", 32'h0, {31'h0, flags.corrupt});
        report_and_stop();
    end
endmodule
`default_nettype wire
